// ===== hdl/ntdc_cfg.svh
// Purpose: constants for the transmitter driver control block
// Assumes: apb, 32-bit data, one aligned word per register
// Notes: offsets are byte addresses
`ifndef NTDC_CFG_SVH
`define NTDC_CFG_SVH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define NTDC_OFS_OPCTL 12'h000
`define NTDC_OFS_IOCFG 12'h004
`define NTDC_OFS_MODE 12'h008
`define NTDC_OFS_TXDRV 12'h00C
`define NTDC_OFS_PTMOD 12'h010
`define NTDC_OFS_STAT 12'h014
// ----------------------------------------
// field positions
// ----------------------------------------
`define NTDC_OP_TX_EN 0
`define NTDC_OP_RX_EN 1
`define NTDC_OP_PT_MODE 2
`define NTDC_IO_SINGLE 0
`define NTDC_IO_OUTSEL 1
`define NTDC_IO_SLOW 2
`define NTDC_MD_AM 0
`define NTDC_MD_DRI 1
`define NTDC_MD_EXT 2
`define NTDC_MD_POL 3
// ----------------------------------------
// reset values
// ----------------------------------------
`define NTDC_RST_DRES 4'h0
`define NTDC_RST_AMLVL 4'h0
`define NTDC_RST_PTRES 4'h0
`define NTDC_RST_PTMRES 4'h0
// ----------------------------------------
// timing
// ----------------------------------------
`define NTDC_CLK_MHZ 125
`define NTDC_RAMP_STEP_NS 2000
`define NTDC_RAMP_STEP_CYC ((`NTDC_RAMP_STEP_NS * `NTDC_CLK_MHZ) / 1000)
`endif

// ===== hdl/ntdc_pkg.sv
// Purpose: types for the transmitter driver control block
// Assumes: included header holds numbers
// Notes: none
package ntdc_pkg;
   typedef enum logic [1:0] {
      NTDC_SUP_OFF,
      NTDC_SUP_RAMP,
      NTDC_SUP_FULL
   } ntdc_sup_t;
   typedef struct packed {
      logic [7:0] seg_a;
      logic [7:0] seg_b;
      logic carrier_a;
      logic carrier_b;
   } ntdc_drv_t;
   typedef struct packed {
      logic sel_am;
      logic sel_main;
      logic [3:0] am_level;
      logic [7:0] ramp_level;
   } ntdc_sup_ctl_t;
endpackage : ntdc_pkg

// ===== hdl/ntdc_seg_map.sv
// Purpose: maps a 4-bit resistance code onto eight driver segments
// Assumes: code 0 is the lowest resistance
// Notes: pure combinational
`timescale 1ns/1ns
module ntdc_seg_map (
   input wire logic [3:0] code,
   output logic [7:0] seg
);
   // ----------------------------------------
   // decode
   // ----------------------------------------
   // msb segments drop first, raising impedance; binary weights by position
   always_comb begin
      seg = 8'hFF >> code[2:0]; // [R2] [R4]
      if (code[3]) begin
         seg = seg & 8'h0F;
      end
   end
endmodule : ntdc_seg_map

// ===== hdl/ntdc_ramp.sv
// Purpose: slow ramp of the driver supply
// Assumes: step period from header
// Notes: level 8'hFF is full supply
`timescale 1ns/1ns
`include "ntdc_cfg.svh"
module ntdc_ramp #(
   parameter int STEP_CYC = `NTDC_RAMP_STEP_CYC
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic tx_en,
   input wire logic slow,
   output logic [7:0] level_q,
   output ntdc_pkg::ntdc_sup_t state_q
);
   logic [15:0] cnt_q;
   // the step counter is 16 bits wide, so longer steps cannot be served
   if (STEP_CYC < 1 || STEP_CYC > 65535) begin : g_bad_step
      $error("ntdc_ramp: STEP_CYC out of range");
   end
   // ----------------------------------------
   // supply state
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= ntdc_pkg::NTDC_SUP_OFF;
         level_q <= 8'h00;
         cnt_q <= 16'h0000;
      end else if (!tx_en) begin
         state_q <= ntdc_pkg::NTDC_SUP_OFF;
         level_q <= slow ? 8'h00 : 8'hFF; // [R17] collapse only in slow mode
         cnt_q <= 16'h0000;
      end else begin
         unique case (state_q)
            ntdc_pkg::NTDC_SUP_OFF: begin
               if (slow) begin
                  state_q <= ntdc_pkg::NTDC_SUP_RAMP; // [R17]
               end else begin
                  state_q <= ntdc_pkg::NTDC_SUP_FULL;
                  level_q <= 8'hFF; // [R16]
               end
            end
            ntdc_pkg::NTDC_SUP_RAMP: begin
               if (cnt_q == 16'(STEP_CYC - 1)) begin
                  cnt_q <= 16'h0000;
                  level_q <= level_q + 8'h01;
                  if (level_q == 8'hFE) begin
                     state_q <= ntdc_pkg::NTDC_SUP_FULL;
                  end
               end else begin
                  cnt_q <= cnt_q + 16'h0001;
               end
            end
            ntdc_pkg::NTDC_SUP_FULL: begin
               level_q <= 8'hFF;
            end
         endcase
      end
   end
endmodule : ntdc_ramp

// ===== hdl/ntdc_top.sv
// Purpose: control of the reader rf transmitter drivers
// Assumes: apb slave at 125 MHz; tx_mod and ext_mod_sig come from same-clock logic
// Notes: pt_clk_present is a pin level and is synchronised
//
// The APB slave port and the address map were chosen for this implementation.
`timescale 1ns/1ns
`include "ntdc_cfg.svh"
// Notes on behaviour
// [R1] single mode drives one output; selector picks output and receiver pair
// [R2] each driver has eight binary weighted switchable segments
// [R3] 4-bit resistance field sets idle level; reset is lowest resistance
// [R4] msb segments can be switched off for higher impedance
// [R5] toggling the selector in single mode moves transmission between outputs
// [R6] mode bit picks amplitude modulation or on-off keying
// [R7] on-off keying stops the carrier while modulating
// [R8] amplitude modulation switches driver supply to am regulator while modulating
// [R9] 4-bit am level field sets modulation depth
// [R10] software enables am and programs level for the relevant protocols
// [R11] separate enables for driver and external load modulation, both allowed
// [R12] two 4-bit impedance fields for idle and modulated, any order
// [R13] external pin carries load modulation signal when enabled
// [R14] polarity bit inverts the external modulation pin
// [R15] impedances reach drivers only while extracted clock is present
// [R16] without slow ramp, enabling transmitter gives full power at once
// [R17] with slow ramp, supply collapses when off and ramps when enabled
// [R18] software sets slow ramp, waits 2 ms, enables, then clears it
// [R19] transmitter enable is independent of the receiver enable
// [R20] modulation-state input switches between idle and modulated settings
module ntdc_top #(
   parameter int STEP_CYC = `NTDC_RAMP_STEP_CYC
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic tx_mod,
   input wire logic ext_mod_sig,
   input wire logic pt_clk_present,
   output ntdc_pkg::ntdc_drv_t drv_q,
   output ntdc_pkg::ntdc_sup_ctl_t sup_q,
   output logic ext_modulation_pin,
   output logic rx_input_sel_b,
   output logic rx_en
);
   // ----------------------------------------
   // registers
   // ----------------------------------------
   logic tx_en_q;
   logic rx_en_q;
   logic pt_mode_q;
   logic single_q;
   logic output_select_q;
   logic slow_q;
   logic am_not_ook_sel_q;
   logic driver_loadmod_en_q;
   logic external_loadmod_en_q;
   logic external_loadmod_invert_q;
   logic [3:0] d_level_q;
   logic [3:0] am_level_q;
   logic [3:0] target_idle_impedance_q;
   logic [3:0] target_mod_impedance_q;
   logic [31:0] prdata_q;
   logic pslverr_q;
   logic pready_q;
   logic ptclk_s1_q;
   logic ptclk_s2_q;
   logic ext_pin_q;
   logic rx_sel_q;
   logic rx_en_o_q;
   ntdc_pkg::ntdc_drv_t drv_d;
   ntdc_pkg::ntdc_sup_ctl_t sup_d;
   logic [7:0] ramp_level;
   ntdc_pkg::ntdc_sup_t ramp_state;
   logic [7:0] seg_idle;
   logic [7:0] seg_pt_idle;
   logic [7:0] seg_pt_mod;
   logic [7:0] seg_sel;
   logic wr_en;
   logic acc;
   logic hit;

   function automatic logic known_addr(input logic [11:0] a);
      known_addr = (a == `NTDC_OFS_OPCTL) || (a == `NTDC_OFS_IOCFG) ||
         (a == `NTDC_OFS_MODE) || (a == `NTDC_OFS_TXDRV) ||
         (a == `NTDC_OFS_PTMOD) || (a == `NTDC_OFS_STAT);
   endfunction : known_addr

   // ----------------------------------------
   // apb slave
   // ----------------------------------------
   // one wait state: setup, first access cycle waits, second completes
   assign acc = psel && penable && !pready_q;
   assign hit = known_addr(paddr);
   assign wr_en = psel && penable && pready_q && pwrite && hit;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_q <= 1'b0;
      end else begin
         pready_q <= acc;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q <= 32'h0000_0000;
         pslverr_q <= 1'b0;
      end else if (acc) begin
         pslverr_q <= !hit;
         prdata_q <= 32'h0000_0000;
         if (!pwrite) begin
            unique case (paddr)
               `NTDC_OFS_OPCTL: prdata_q <= {29'h0, pt_mode_q, rx_en_q, tx_en_q};
               `NTDC_OFS_IOCFG: prdata_q <= {29'h0, slow_q, output_select_q, single_q};
               `NTDC_OFS_MODE: prdata_q <= {28'h0, external_loadmod_invert_q,
                  external_loadmod_en_q, driver_loadmod_en_q, am_not_ook_sel_q};
               `NTDC_OFS_TXDRV: prdata_q <= {24'h0, am_level_q, d_level_q};
               `NTDC_OFS_PTMOD: prdata_q <= {24'h0, target_mod_impedance_q,
                  target_idle_impedance_q};
               `NTDC_OFS_STAT: prdata_q <= {21'h0, ptclk_s2_q, ramp_state, ramp_level};
               default: prdata_q <= 32'h0000_0000;
            endcase
         end
      end else begin
         pslverr_q <= 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_en_q <= 1'b0;
         rx_en_q <= 1'b0;
         pt_mode_q <= 1'b0;
      end else if (wr_en && paddr == `NTDC_OFS_OPCTL) begin
         tx_en_q <= pwdata[`NTDC_OP_TX_EN]; // [R19]
         rx_en_q <= pwdata[`NTDC_OP_RX_EN]; // [R19]
         pt_mode_q <= pwdata[`NTDC_OP_PT_MODE];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         single_q <= 1'b0;
         output_select_q <= 1'b0;
         slow_q <= 1'b0;
      end else if (wr_en && paddr == `NTDC_OFS_IOCFG) begin
         single_q <= pwdata[`NTDC_IO_SINGLE];
         output_select_q <= pwdata[`NTDC_IO_OUTSEL]; // [R5]
         slow_q <= pwdata[`NTDC_IO_SLOW];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         am_not_ook_sel_q <= 1'b0;
         driver_loadmod_en_q <= 1'b0;
         external_loadmod_en_q <= 1'b0;
         external_loadmod_invert_q <= 1'b0;
      end else if (wr_en && paddr == `NTDC_OFS_MODE) begin
         am_not_ook_sel_q <= pwdata[`NTDC_MD_AM]; // [R6]
         driver_loadmod_en_q <= pwdata[`NTDC_MD_DRI]; // [R11]
         external_loadmod_en_q <= pwdata[`NTDC_MD_EXT]; // [R11]
         external_loadmod_invert_q <= pwdata[`NTDC_MD_POL];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         d_level_q <= `NTDC_RST_DRES; // [R3]
         am_level_q <= `NTDC_RST_AMLVL;
      end else if (wr_en && paddr == `NTDC_OFS_TXDRV) begin
         d_level_q <= pwdata[3:0]; // [R3]
         am_level_q <= pwdata[7:4]; // [R9]
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         target_idle_impedance_q <= `NTDC_RST_PTRES;
         target_mod_impedance_q <= `NTDC_RST_PTMRES;
      end else if (wr_en && paddr == `NTDC_OFS_PTMOD) begin
         target_idle_impedance_q <= pwdata[3:0]; // [R12]
         target_mod_impedance_q <= pwdata[7:4]; // [R12]
      end
   end

   // ----------------------------------------
   // extracted clock presence
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ptclk_s1_q <= 1'b0;
         ptclk_s2_q <= 1'b0;
      end else begin
         ptclk_s1_q <= pt_clk_present;
         ptclk_s2_q <= ptclk_s1_q;
      end
   end

   // ----------------------------------------
   // segment decode and supply ramp
   // ----------------------------------------
   ntdc_seg_map u_map_idle (.code(d_level_q), .seg(seg_idle));
   ntdc_seg_map u_map_pt_idle (.code(target_idle_impedance_q), .seg(seg_pt_idle));
   ntdc_seg_map u_map_pt_mod (.code(target_mod_impedance_q), .seg(seg_pt_mod));

   ntdc_ramp #(.STEP_CYC(STEP_CYC)) u_ramp (
      .pclk(pclk),
      .presetn(presetn),
      .tx_en(tx_en_q),
      .slow(slow_q),
      .level_q(ramp_level),
      .state_q(ramp_state)
   );

   // ----------------------------------------
   // driver control
   // ----------------------------------------
   always_comb begin
      logic drive;
      drive = 1'b0;
      seg_sel = seg_idle;
      sup_d.sel_am = 1'b0;
      sup_d.sel_main = 1'b1;
      sup_d.am_level = am_level_q; // [R9]
      sup_d.ramp_level = ramp_level; // [R16] [R17]
      if (pt_mode_q) begin
         // impedance only reaches the drivers while the extracted clock runs
         if (ptclk_s2_q && driver_loadmod_en_q) begin // [R15]
            seg_sel = tx_mod ? seg_pt_mod : seg_pt_idle; // [R12] [R20]
            drive = 1'b1;
         end
      end else if (tx_en_q) begin
         drive = 1'b1;
         if (tx_mod && !am_not_ook_sel_q) begin
            drive = 1'b0; // [R7]
         end else if (tx_mod && am_not_ook_sel_q) begin
            sup_d.sel_am = 1'b1; // [R8] [R20]
            sup_d.sel_main = 1'b0; // [R8]
         end
      end
      drv_d.seg_a = (single_q && output_select_q) ? 8'h00 : seg_sel; // [R1]
      drv_d.seg_b = (single_q && !output_select_q) ? 8'h00 : seg_sel; // [R1] [R5]
      drv_d.carrier_a = drive && !(single_q && output_select_q); // [R1]
      drv_d.carrier_b = drive && !(single_q && !output_select_q); // [R1]
      if (!drive) begin
         drv_d.seg_a = 8'h00;
         drv_d.seg_b = 8'h00;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         drv_q <= '0;
         sup_q <= '0;
      end else begin
         drv_q <= drv_d;
         sup_q <= sup_d;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ext_pin_q <= 1'b0;
         rx_sel_q <= 1'b0;
         rx_en_o_q <= 1'b0;
      end else begin
         // idle level also follows the polarity so the gate sits at the inactive state
         ext_pin_q <= (external_loadmod_en_q && ext_mod_sig)
            ^ external_loadmod_invert_q; // [R13] [R14]
         rx_sel_q <= single_q && output_select_q; // [R1]
         rx_en_o_q <= rx_en_q; // [R19]
      end
   end

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign ext_modulation_pin = ext_pin_q;
   assign rx_input_sel_b = rx_sel_q;
   assign rx_en = rx_en_o_q;
endmodule : ntdc_top

// ===== verif/ntdc_asserts.sv
// Purpose: port checks for ntdc_top
// Assumes: registered outputs, apb with one wait state
// Notes: the write window looks three cycles back
`timescale 1ns/1ns
module ntdc_asserts (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic tx_mod,
   input wire logic ext_mod_sig,
   input wire ntdc_pkg::ntdc_drv_t drv_q,
   input wire ntdc_pkg::ntdc_sup_ctl_t sup_q,
   input wire logic ext_modulation_pin,
   input wire logic rx_input_sel_b,
   input wire logic rx_en
);
   // ------------------------------
   // helpers and checks
   // ------------------------------
   logic [2:0] wr_q;
   logic [2:0] sig_q;
   logic wr_near;
   logic sig_moved;
   // outputs may lag the register write by two cycles, so the window is loose
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wr_q <= 3'h0;
         sig_q <= 3'h0;
      end else begin
         wr_q <= {wr_q[1:0], pready & pwrite};
         sig_q <= {sig_q[1:0], ext_mod_sig};
      end
   end
   assign wr_near = (|wr_q) | (pready & pwrite);
   assign sig_moved = ({sig_q, ext_mod_sig} != 4'h0) && ({sig_q, ext_mod_sig} != 4'hF);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_ready_one_wait: assert property (psel && penable && !pready |=> pready)
      else $error("pready late");
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("pready held");
   a_err_with_ready: assert property (pslverr |-> pready)
      else $error("pslverr alone");
   a_am_follows_mod: assert property (sup_q.sel_am |-> $past(tx_mod))
      else $error("am supply without modulation");
   a_am_excl_main: assert property (sup_q.sel_am |-> !sup_q.sel_main)
      else $error("both supplies selected");
   a_am_switch_cause: assert property ($changed(sup_q.sel_am) |->
      ($past(tx_mod) != $past(tx_mod, 2)) || wr_near)
      else $error("supply switch without cause");
   a_single_b_only: assert property (rx_input_sel_b && $past(rx_input_sel_b)
      |-> !drv_q.carrier_a)
      else $error("output a driven in single b");
   a_sel_by_write: assert property ($changed(rx_input_sel_b) |-> wr_near)
      else $error("selector moved without write");
   a_rx_by_write: assert property ($changed(rx_en) |-> wr_near)
      else $error("rx enable moved without write");
   a_ext_pin_cause: assert property ($changed(ext_modulation_pin)
      |-> sig_moved || wr_near)
      else $error("ext pin moved without cause");
endmodule : ntdc_asserts

// ===== verif/ntdc_tank_model.sv
// Purpose: antenna tank and clock extraction at the driver pins
// Assumes: an outside reader field is a plain level
// Notes: clock extraction is modelled as one cycle of lag
`timescale 1ns/1ns
module ntdc_tank_model (
   input wire logic pclk,
   input wire ntdc_pkg::ntdc_drv_t drv_q,
   input wire logic outside_field,
   output logic pt_clk_present,
   output logic field_on
);
   // ------------------------------
   // tank
   // ------------------------------
   // no outside field means no extracted clock at all
   always_ff @(posedge pclk) begin
      pt_clk_present <= outside_field;
   end
   // field decays one cycle after neither carrier is driven, a high-q tank would lag longer
   always_ff @(posedge pclk) begin
      field_on <= drv_q.carrier_a | drv_q.carrier_b;
   end
endmodule : ntdc_tank_model

// ===== verif/ntdc_top_tb.sv
// Purpose: self-checking bench for ntdc_top
// Assumes: ramp step shortened to STEP cycles
// Notes: outputs sampled a few cycles after each change
`timescale 1ns/1ns
`include "ntdc_cfg.svh"
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin mismatches++; \
   $display("MISMATCH %s exp %0h got %0h", n, e, g); end end
module ntdc_top_tb;
   // ------------------------------
   // bench
   // ------------------------------
   localparam int STEP = 2;
   localparam logic [31:0] MSK [5] = '{32'h7, 32'h7, 32'hF, 32'hFF, 32'hFF};
   // segment pattern per resistance code, written out from the agreed map
   localparam logic [7:0] SEG_TAB [16] = '{8'hFF, 8'h7F, 8'h3F, 8'h1F, 8'h0F, 8'h07,
      8'h03, 8'h01, 8'h0F, 8'h0F, 8'h0F, 8'h0F, 8'h0F, 8'h07, 8'h03, 8'h01};
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic tx_mod = 1'b0;
   logic ext_mod_sig = 1'b0;
   logic outside_field = 1'b0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic pt_clk_present;
   logic field_on;
   ntdc_pkg::ntdc_drv_t drv_q;
   ntdc_pkg::ntdc_sup_ctl_t sup_q;
   logic ext_modulation_pin;
   logic rx_input_sel_b;
   logic rx_en;
   logic [31:0] rd;
   logic err;
   int mismatches = 0;
   int tests_run = 0;
   initial forever #4 pclk = ~pclk;
   ntdc_top #(.STEP_CYC(STEP)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .tx_mod(tx_mod), .ext_mod_sig(ext_mod_sig),
      .pt_clk_present(pt_clk_present), .drv_q(drv_q), .sup_q(sup_q),
      .ext_modulation_pin(ext_modulation_pin), .rx_input_sel_b(rx_input_sel_b), .rx_en(rx_en));
   ntdc_tank_model tank (.pclk(pclk), .drv_q(drv_q), .outside_field(outside_field),
      .pt_clk_present(pt_clk_present), .field_on(field_on));
   function automatic logic [7:0] seg_exp(input logic [3:0] c);
      seg_exp = SEG_TAB[c];
   endfunction : seg_exp
   task automatic end_sim();
      $display("checks %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : end_sim
   task automatic wt(input int c);
      repeat (c) @(posedge pclk);
   endtask : wt
   // holds the request until pready, then idles one cycle before any next call
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 20) begin
         mismatches++;
         end_sim();
      end
      @(posedge pclk);
   endtask : apb
   initial begin
      int n;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      for (int i = 0; i < 5; i++) begin
         apb(1'b0, 12'(i * 4), 32'h0);
         `CHK("reset", 32'h0, rd)
         apb(1'b1, 12'(i * 4), 32'hFFFFFFFF);
         apb(1'b0, 12'(i * 4), 32'h0);
         `CHK("mask", MSK[i], rd)
         apb(1'b1, 12'(i * 4), 32'h0);
      end
      apb(1'b0, 12'h018, 32'h0);
      `CHK("unmapped", 2'b01, {rd != 32'h0, err})
      $display("test registers done");
      apb(1'b1, `NTDC_OFS_OPCTL, 32'h2);
      wt(3);
      `CHK("rx only", 1'b1, rx_en)
      `CHK("rx only tx", 2'b00, {drv_q.carrier_a, drv_q.carrier_b})
      apb(1'b1, `NTDC_OFS_OPCTL, 32'h1);
      wt(6);
      `CHK("rx_en", 1'b0, rx_en)
      `CHK("carriers", 2'b11, {drv_q.carrier_a, drv_q.carrier_b})
      `CHK("full", 8'hFF, sup_q.ramp_level)
      `CHK("field", 1'b1, field_on)
      `CHK("lowest res", 8'hFF, drv_q.seg_a)
      for (int c = 0; c < 16; c++) begin
         apb(1'b1, `NTDC_OFS_TXDRV, 32'(c));
         wt(3);
         `CHK("seg_a", seg_exp(4'(c)), drv_q.seg_a)
         `CHK("seg_b", seg_exp(4'(c)), drv_q.seg_b)
      end
      $display("test resistance done");
      apb(1'b1, `NTDC_OFS_TXDRV, 32'h50);
      for (int m = 0; m < 2; m++) begin
         apb(1'b1, `NTDC_OFS_MODE, 32'(m));
         tx_mod <= 1'b1;
         wt(3);
         `CHK("mod carrier", m ? 2'b11 : 2'b00, {drv_q.carrier_a, drv_q.carrier_b})
         `CHK("mod supply", m ? 2'b10 : 2'b01, {sup_q.sel_am, sup_q.sel_main})
         `CHK("am level", 4'h5, sup_q.am_level)
         tx_mod <= 1'b0;
         wt(3);
         `CHK("idle carrier", 2'b11, {drv_q.carrier_a, drv_q.carrier_b})
         `CHK("idle supply", 2'b01, {sup_q.sel_am, sup_q.sel_main})
      end
      $display("test modulation done");
      for (int s = 0; s < 2; s++) begin
         apb(1'b1, `NTDC_OFS_IOCFG, 32'(1 + 2 * s));
         wt(4);
         `CHK("single", s ? 2'b01 : 2'b10, {drv_q.carrier_a, drv_q.carrier_b})
         `CHK("rx pair", 1'(s), rx_input_sel_b)
      end
      apb(1'b1, `NTDC_OFS_IOCFG, 32'h0);
      $display("test single done");
      apb(1'b1, `NTDC_OFS_MODE, 32'h6);
      ext_mod_sig <= 1'b1;
      wt(3);
      `CHK("ext on", 1'b1, ext_modulation_pin)
      ext_mod_sig <= 1'b0;
      wt(3);
      `CHK("ext off", 1'b0, ext_modulation_pin)
      apb(1'b1, `NTDC_OFS_MODE, 32'hE);
      wt(3);
      `CHK("ext inv", 1'b1, ext_modulation_pin)
      apb(1'b1, `NTDC_OFS_MODE, 32'h8);
      wt(3);
      `CHK("ext dis", 1'b1, ext_modulation_pin)
      $display("test external done");
      apb(1'b1, `NTDC_OFS_PTMOD, 32'h83);
      apb(1'b1, `NTDC_OFS_MODE, 32'h2);
      apb(1'b1, `NTDC_OFS_OPCTL, 32'h4);
      wt(3);
      `CHK("pt no clock", 8'h00, drv_q.seg_a)
      outside_field <= 1'b1;
      wt(6);
      `CHK("pt idle", seg_exp(4'h3), drv_q.seg_a)
      tx_mod <= 1'b1;
      wt(3);
      `CHK("pt mod", seg_exp(4'h8), drv_q.seg_a)
      tx_mod <= 1'b0;
      outside_field <= 1'b0;
      apb(1'b1, `NTDC_OFS_OPCTL, 32'h0);
      apb(1'b1, `NTDC_OFS_MODE, 32'h0);
      $display("test target done");
      apb(1'b1, `NTDC_OFS_IOCFG, 32'h4);
      wt(20);
      `CHK("collapsed", 8'h00, sup_q.ramp_level)
      apb(1'b1, `NTDC_OFS_OPCTL, 32'h1);
      `CHK("ramping", 1'b1, sup_q.ramp_level !== 8'hFF)
      n = 0;
      while (sup_q.ramp_level !== 8'hFF && n < 2000) begin
         @(posedge pclk);
         n++;
      end
      `CHK("ramp time", 1'b1, n > 255 && n < 2000)
      if (n >= 2000) begin
         end_sim();
      end
      apb(1'b1, `NTDC_OFS_IOCFG, 32'h0);
      $display("test ramp done");
      end_sim();
   end
   initial begin
      #400000;
      mismatches++;
      end_sim();
   end
endmodule : ntdc_top_tb
bind ntdc_top ntdc_asserts chk (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .pready(pready), .pslverr(pslverr), .tx_mod(tx_mod),
   .ext_mod_sig(ext_mod_sig), .drv_q(drv_q), .sup_q(sup_q),
   .ext_modulation_pin(ext_modulation_pin), .rx_input_sel_b(rx_input_sel_b), .rx_en(rx_en));
